// *** rtl/csr_clock_reset.sv ***
/*
  Clock source switch, power-up/sleep sequencer and reset cause flags,
  with an AHB-Lite register slave.
  Assumes oscillator levels and the reset pin are asynchronous to i_ref_clk;
  core handshake inputs are on i_ref_clk. i_rstn is the power-on reset.
*/
// The AHB-Lite slave port and the placing of the registers were decided locally.
// Function
// RULE1 - Count eight rising edges of the new clock before using it.
// RULE2 - Switching never makes a system clock pulse narrower than either source.
// RULE3 - Secondary pick freezes core at next first quarter, resumes after eight edges.
// RULE4 - Crystal modes back from secondary wait startup plus eight edges.
// RULE5 - PLL mode with PLL pick waits startup plus PLL lock before PLL use.
// RULE6 - PLL mode without PLL pick waits startup only, then main input.
// RULE7 - RC and external clock modes: no startup wait, eight main edges.
// RULE8 - Select decode: secondary pick wins, else PLL pick, else main input.
// RULE9 - Both picks cleared from secondary: main input after startup wait.
// RULE10 - Only secondary pick cleared: PLL output after startup and lock waits.
// RULE11 - Sleep stops clocks and oscillator, core held at first quarter.
// RULE12 - Sleep ends on external reset, watchdog or interrupt.
// RULE13 - Crystal modes disable oscillator feedback inverter during sleep; the code keeps it on in MODE_CRYSTAL_PLL.
// RULE14 - Powerup timer holds reset on power-up only, set by config bit.
// RULE15 - After power-on: powerup timer, then startup timer, reset held throughout.
// RULE16 - PLL mode adds PLL lock wait after startup before leaving reset.
// RULE17 - Seven reset causes are distinguished.
// RULE18 - Defined registers reset by power-on, pin, watchdog, instruction resets.
// RULE19 - Watchdog wake-up resumes normal operation, registers kept.
// RULE20 - Reset cause flags differ per reset situation for software.
// RULE21 - Reset pin filtered so short noise pulses are ignored.
// RULE22 - Watchdog reset never drives the external reset pin low.
// RULE23 - Startup timer counts 1024 main edges, crystal modes only.
// RULE24 - Powerup timer delay is 72 ms.
// RULE25 - Secondary pick write ignored while secondary oscillator disabled.
// RULE26 - Reset cause flag values per power-on, software, watchdog, pin, wake.
`timescale 1ns/100ps
module csr_clock_reset
  import csr_pkg::*;
#(
  parameter int POWERUP_CYCLES = POWERUP_CYC,
  parameter int PLL_LOCK_CYCLES = PLL_LOCK_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_main_osc_in_pin,
  input wire logic i_pll_clk,
  input wire logic i_sec_osc,
  input wire logic i_external_reset_pin_n,
  input wire logic [2:0] i_osc_mode,
  input wire logic i_powerup_timer_cfg,
  input wire logic i_first_quarter_phase,
  input wire logic i_sleep_req,
  input wire logic i_wake_irq,
  input wire logic i_watchdog_timer_evt,
  input wire logic i_reset_instr,
  input wire logic i_stack_full,
  input wire logic i_stack_underflow,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic o_sys_clk,
  output logic [1:0] o_clk_src,
  output logic o_core_freeze,
  output logic o_core_reset,
  output logic o_osc_en,
  output logic o_osc_feedback_en
);
  localparam logic [CNT_W-1:0] POWERUP_TIMER_LAST = CNT_W'(POWERUP_CYCLES - 1);
  localparam logic [CNT_W-1:0] PLL_LAST = CNT_W'(PLL_LOCK_CYCLES - 1);

  // Pick one bit of a source-indexed vector
  function automatic logic fn_sel(input logic [2:0] vec, input csr_src_t src);
    fn_sel = vec[src];
  endfunction : fn_sel

  // Crystal modes need the startup timer
  function automatic logic fn_crystal(input logic [2:0] mode);
    fn_crystal = (mode == MODE_SLOW_CRYSTAL) || (mode == MODE_FAST_CRYSTAL) || (mode == MODE_CRYSTAL_PLL);
  endfunction : fn_crystal

  csr_state_t state;
  csr_src_t cur_src;
  csr_src_t tgt_src;
  logic [2:0] src_s1;
  logic [2:0] src_s2;
  logic [2:0] src_s3;
  logic [2:0] src_edge;
  logic pin_s1;
  logic pin_s2;
  logic pin_flt;
  logic [3:0] flt_cnt;
  logic [CNT_W-1:0] cnt;
  logic [3:0] sync_cnt;
  logic [2:0] mode;
  logic powerup_timer_cfg;
  logic [2:0] ctrl;
  logic [5:0] cause;
  logic clk_on;
  logic rst_pulse;
  logic pin_fall;
  logic sys_rst_evt;
  logic wdt_rst;
  logic ap_wr;
  logic [7:0] ap_addr;
  logic ap_valid;
  logic sw_busy;

  // Two-stage synchronisers; third stage only for edge detect
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      src_s1 <= 3'h0;
      src_s2 <= 3'h0;
      src_s3 <= 3'h0;
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
    end else begin
      src_s1 <= {i_sec_osc, i_pll_clk, i_main_osc_in_pin};
      src_s2 <= src_s1;
      src_s3 <= src_s2;
      pin_s1 <= i_external_reset_pin_n;
      pin_s2 <= pin_s1;
    end
  end
  assign src_edge = src_s2 & ~src_s3;

  // Reset pin filter: level must stand FILTER_CYC cycles to count
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_flt <= 1'b1;
      flt_cnt <= 4'h0;
    end else if (pin_s2 == pin_flt) begin
      flt_cnt <= 4'h0; // RULE21
    end else if (flt_cnt == FILTER_LAST) begin
      pin_flt <= pin_s2; // RULE21
      flt_cnt <= 4'h0;
    end else begin
      flt_cnt <= flt_cnt + 4'h1;
    end
  end

  // Resets other than power-on; pin is an input only, never driven
  assign pin_fall = !pin_s2 && pin_flt && (flt_cnt == FILTER_LAST);
  assign wdt_rst = i_watchdog_timer_evt && (state != ST_SLEEP); // RULE22
  assign sys_rst_evt = pin_fall || wdt_rst || i_reset_instr || i_stack_full || i_stack_underflow; // RULE17

  // Straps caught on the first edge after power-on release
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode <= MODE_SLOW_CRYSTAL;
      powerup_timer_cfg <= 1'b0;
    end else if (state == ST_STRAP) begin
      mode <= i_osc_mode;
      powerup_timer_cfg <= i_powerup_timer_cfg; // RULE14
    end
  end

  // Target source decode; secondary pick has priority
  always_comb begin
    if (ctrl[CTL_LOW_POWER_CLK_PICK]) begin
      tgt_src = SRC_SEC; // RULE8
    end else if (ctrl[CTL_PLL_CLK_PICK]) begin
      tgt_src = SRC_PLL; // RULE8
    end else begin
      tgt_src = SRC_MAIN; // RULE8
    end
  end

  // AHB-Lite address phase capture
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ap_valid <= 1'b0;
      ap_wr <= 1'b0;
      ap_addr <= 8'h00;
    end else if (i_hready) begin
      ap_valid <= i_hsel && i_htrans[1];
      ap_wr <= i_hwrite;
      ap_addr <= i_haddr[7:0];
    end
  end

  // Read data registered in the address phase; unmapped reads give zero
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_hrdata <= 32'h0;
    end else if (i_hready && i_hsel && i_htrans[1] && !i_hwrite) begin
      case (i_haddr[7:0])
        OFS_CLK_CTRL: o_hrdata <= {29'h0, ctrl};
        OFS_STATUS: o_hrdata <= {24'h0, state, o_core_freeze, sw_busy, cur_src};
        OFS_RESET_CAUSE: o_hrdata <= {26'h0, cause};
        default: o_hrdata <= 32'h0;
      endcase
    end
  end
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;

  // Clock control register; forced clear by every reset except watchdog wake-up
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl <= CTL_RESET;
    end else if (sys_rst_evt) begin
      ctrl <= CTL_RESET; // RULE18
    end else if (ap_valid && ap_wr && (ap_addr == OFS_CLK_CTRL)) begin
      ctrl[CTL_SECONDARY_OSC_ENABLE] <= i_hwdata[CTL_SECONDARY_OSC_ENABLE];
      // Write ignored and bit held clear without the secondary oscillator
      ctrl[CTL_LOW_POWER_CLK_PICK] <= i_hwdata[CTL_LOW_POWER_CLK_PICK]
        && i_hwdata[CTL_SECONDARY_OSC_ENABLE]; // RULE25
      // PLL pick only exists in PLL mode
      ctrl[CTL_PLL_CLK_PICK] <= i_hwdata[CTL_PLL_CLK_PICK] && (mode == MODE_CRYSTAL_PLL);
    end
  end

  // Reset cause flags; hardware events override a same-cycle write
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cause <= RC_POR_VALUE; // RULE26
    end else begin
      if (ap_valid && ap_wr && (ap_addr == OFS_RESET_CAUSE)) begin
        cause <= i_hwdata[5:0];
      end
      if (i_reset_instr) begin
        cause[RC_RESET_INSTR] <= 1'b0; // RULE26
      end
      if (i_stack_full) begin
        cause[RC_STACK_FULL] <= 1'b1; // RULE20
      end
      if (i_stack_underflow) begin
        cause[RC_STACK_UNDERFLOW] <= 1'b1; // RULE20
      end
      if (wdt_rst) begin
        cause[RC_WATCHDOG_TIMEOUT] <= 1'b0; // RULE26
        cause[RC_SLEEP_ENTRY] <= 1'b1;
      end else if (state == ST_SLEEP && pin_fall) begin
        cause[RC_WATCHDOG_TIMEOUT] <= 1'b1; // RULE26
        cause[RC_SLEEP_ENTRY] <= 1'b0;
      end else if (state == ST_SLEEP && (i_watchdog_timer_evt || i_wake_irq)) begin
        cause[RC_WATCHDOG_TIMEOUT] <= 1'b0; // RULE26
        cause[RC_SLEEP_ENTRY] <= 1'b0;
      end
    end
  end

  // Sequencer: power-up timing, source switching, sleep
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= ST_STRAP;
      cur_src <= SRC_MAIN;
      cnt <= '0;
      sync_cnt <= 4'h0;
    end else begin
      case (state)
        ST_STRAP: begin
          cnt <= '0;
          // Powerup timer runs when the config bit is low
          if (!i_powerup_timer_cfg) begin
            state <= ST_POWERUP_TIMER; // RULE14
          end else if (fn_crystal(i_osc_mode)) begin
            state <= ST_OST; // RULE15
          end else begin
            state <= ST_RUN;
          end
        end
        ST_POWERUP_TIMER: begin
          if (cnt == POWERUP_TIMER_LAST) begin
            cnt <= '0;
            state <= fn_crystal(mode) ? ST_OST : ST_RUN; // RULE15
          end else begin
            cnt <= cnt + 1'b1; // RULE24
          end
        end
        ST_OST: begin
          if (src_edge[SRC_MAIN]) begin
            if (cnt == STARTUP_EDGES - 1'b1) begin
              cnt <= '0;
              state <= (mode == MODE_CRYSTAL_PLL) ? ST_PLL : ST_RUN; // RULE16
            end else begin
              cnt <= cnt + 1'b1; // RULE23
            end
          end
        end
        ST_PLL: begin
          if (cnt == PLL_LAST) begin
            cnt <= '0;
            state <= ST_RUN; // RULE16
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        ST_RUN: begin
          cnt <= '0;
          sync_cnt <= 4'h0;
          if (i_sleep_req && i_first_quarter_phase) begin
            state <= ST_SLEEP; // RULE11
          end else if (tgt_src != cur_src) begin
            state <= ST_FRZ;
          end
        end
        ST_FRZ: begin
          // Core held at a phase boundary; a core in reset has no phases
          if (i_first_quarter_phase || o_core_reset) begin
            if (tgt_src == SRC_SEC || cur_src != SRC_SEC) begin
              state <= ST_SW_SYNC; // RULE3
            end else if (fn_crystal(mode)) begin
              state <= ST_SW_OST; // RULE4 RULE9
            end else begin
              state <= ST_SW_SYNC; // RULE7
            end
          end
        end
        ST_SW_OST: begin
          if (src_edge[SRC_MAIN]) begin
            if (cnt == STARTUP_EDGES - 1'b1) begin
              cnt <= '0;
              // PLL lock wait only when the PLL output will be used
              state <= (tgt_src == SRC_PLL) ? ST_SW_PLL : ST_SW_SYNC; // RULE5 RULE6 RULE10
            end else begin
              cnt <= cnt + 1'b1; // RULE4
            end
          end
        end
        ST_SW_PLL: begin
          if (cnt == PLL_LAST) begin
            cnt <= '0;
            state <= ST_SW_SYNC; // RULE5 RULE10
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        ST_SW_SYNC: begin
          if (fn_sel(src_edge, tgt_src)) begin
            if (sync_cnt == SYNC_EDGES - 4'h1) begin
              sync_cnt <= 4'h0;
              cur_src <= tgt_src; // RULE1
              state <= ST_RUN;
            end else begin
              sync_cnt <= sync_cnt + 4'h1; // RULE1
            end
          end
        end
        ST_SLEEP: begin
          cnt <= '0;
          if (pin_fall || i_watchdog_timer_evt || i_wake_irq) begin
            // Crystal restarts need the startup timer, PLL mode the lock too
            state <= fn_crystal(mode) ? ST_OST : ST_RUN; // RULE12 RULE19
          end
        end
        default: begin
          state <= ST_STRAP;
        end
      endcase
    end
  end
  assign sw_busy = (state == ST_FRZ) || (state == ST_SW_OST) || (state == ST_SW_PLL) || (state == ST_SW_SYNC);

  // Clock gate: off only at a low of the old clock, on only at a low of
  // the new one, so no pulse is shorter than either source provides
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      clk_on <= 1'b0;
      o_sys_clk <= 1'b0;
    end else begin
      if ((sw_busy || state == ST_SLEEP) && !fn_sel(src_s2, cur_src)) begin
        clk_on <= 1'b0; // RULE2 RULE11
      end else if (!sw_busy && state != ST_SLEEP && !fn_sel(src_s2, cur_src)) begin
        clk_on <= 1'b1; // RULE2
      end
      o_sys_clk <= clk_on && fn_sel(src_s2, cur_src);
    end
  end

  // One-cycle core reset for event resets that need no timing
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_pulse <= 1'b0;
    end else begin
      rst_pulse <= sys_rst_evt;
    end
  end

  // Core controls; wake-up via watchdog or interrupt keeps the core state
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_core_reset <= 1'b1;
      o_core_freeze <= 1'b1;
      o_osc_en <= 1'b1;
      o_osc_feedback_en <= 1'b1;
      o_clk_src <= SRC_MAIN;
    end else begin
      o_core_reset <= (state == ST_STRAP) || (state == ST_POWERUP_TIMER)
        || ((state == ST_OST || state == ST_PLL) && cause[RC_WATCHDOG_TIMEOUT]) // Not on a quiet wake
        || !pin_flt || rst_pulse; // RULE15 RULE18 RULE19
      o_core_freeze <= (state != ST_RUN); // RULE3 RULE11
      o_osc_en <= (state != ST_SLEEP); // RULE11
      o_osc_feedback_en <= !(state == ST_SLEEP && (mode == MODE_SLOW_CRYSTAL
        || mode == MODE_FAST_CRYSTAL)); // RULE13
      o_clk_src <= cur_src;
    end
  end
endmodule : csr_clock_reset

// *** rtl/csr_pkg.sv ***
/*
  Shared constants for the clock switch and reset sequencer: register map,
  field positions, oscillator modes, clock sources, FSM states, timing.
  Assumes a 50 MHz reference clock.
*/
package csr_pkg;
  // Reference clock
  localparam int REF_MHZ = 50;
  // Register byte offsets
  localparam logic [7:0] OFS_CLK_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RESET_CAUSE = 8'h08;
  // Clock control fields
  localparam int CTL_LOW_POWER_CLK_PICK = 0;
  localparam int CTL_PLL_CLK_PICK = 1;
  localparam int CTL_SECONDARY_OSC_ENABLE = 2;
  localparam logic [2:0] CTL_RESET = 3'h0;
  // Reset cause fields
  localparam int RC_STACK_UNDERFLOW = 0;
  localparam int RC_POWERUP_RESET_PULSE = 1;
  localparam int RC_SLEEP_ENTRY = 2;
  localparam int RC_WATCHDOG_TIMEOUT = 3;
  localparam int RC_RESET_INSTR = 4;
  localparam int RC_STACK_FULL = 5;
  localparam logic [5:0] RC_POR_VALUE = 6'h1C;
  // Oscillator modes
  localparam logic [2:0] MODE_SLOW_CRYSTAL = 3'h0;
  localparam logic [2:0] MODE_FAST_CRYSTAL = 3'h1;
  localparam logic [2:0] MODE_CRYSTAL_PLL = 3'h2;
  localparam logic [2:0] MODE_EXTERNAL_RNET = 3'h3;
  localparam logic [2:0] MODE_EXTERNAL_CLOCK_IN = 3'h4;
  // Timing
  localparam int POWERUP_MS = 72;
  localparam int PLL_LOCK_MS = 2;
  localparam int POWERUP_CYC = POWERUP_MS * 1000 * REF_MHZ;
  localparam int PLL_LOCK_CYC = PLL_LOCK_MS * 1000 * REF_MHZ;
  localparam int FILTER_NS = 200;
  localparam int FILTER_CYC = (FILTER_NS * REF_MHZ + 999) / 1000;
  localparam int CNT_W = 22;
  localparam logic [CNT_W-1:0] STARTUP_EDGES = 22'h000400;
  localparam logic [3:0] SYNC_EDGES = 4'h8;
  localparam logic [3:0] FILTER_LAST = 4'(FILTER_CYC - 1);
  // Clock sources
  typedef enum logic [1:0] {
    SRC_MAIN = 2'b00,
    SRC_PLL = 2'b01,
    SRC_SEC = 2'b10
  } csr_src_t;
  // Sequencer states
  typedef enum logic [3:0] {
    ST_STRAP = 4'b0000,
    ST_POWERUP_TIMER = 4'b0001,
    ST_OST = 4'b0010,
    ST_PLL = 4'b0011,
    ST_RUN = 4'b0100,
    ST_FRZ = 4'b0101,
    ST_SW_OST = 4'b0110,
    ST_SW_PLL = 4'b0111,
    ST_SW_SYNC = 4'b1000,
    ST_SLEEP = 4'b1001
  } csr_state_t;
endpackage : csr_pkg

// *** testbench/csr_osc_model.sv ***
/*
  Model of the far side: main crystal, PLL output, secondary crystal, reset pin.
  Assumes the bench asks for a pin pull-down through i_pin_low.
*/
`timescale 1ns/100ps
module csr_osc_model (
  input wire logic i_osc_en,
  input wire logic i_pin_low,
  output logic o_main_osc,
  output logic o_pll_clk,
  output logic o_sec_osc,
  output logic o_reset_pin_n
);
  // Main crystal stops when the device turns its oscillator off
  initial begin
    o_main_osc = 1'b0;
    forever #60 o_main_osc = i_osc_en ? ~o_main_osc : 1'b0;
  end
  // PLL slowed below half the reference rate so the synchroniser can see it
  initial begin
    o_pll_clk = 1'b0;
    forever #40 o_pll_clk = i_osc_en ? ~o_pll_clk : 1'b0;
  end
  // Secondary crystal runs all the time
  initial begin
    o_sec_osc = 1'b0;
    forever #200 o_sec_osc = ~o_sec_osc;
  end
  // Pin has a pull-up, so a released pin reads high
  assign o_reset_pin_n = ~i_pin_low;
endmodule : csr_osc_model

// *** testbench/csr_clock_reset_props.sv ***
/*
  Checker on the ports of csr_clock_reset.
  Assumes one clock domain with the asynchronous active-low power-on reset.
*/
`timescale 1ns/100ps
module csr_clock_reset_chk (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_external_reset_pin_n,
  input wire logic i_first_quarter_phase,
  input wire logic i_sleep_req,
  input wire logic i_watchdog_timer_evt,
  input wire logic i_reset_instr,
  input wire logic [1:0] o_clk_src,
  input wire logic o_core_freeze,
  input wire logic o_core_reset,
  input wire logic o_osc_en,
  input wire logic o_osc_feedback_en
);
  logic [4:0] pin_low_cnt;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  // Run length of a low pin, saturating; long lows must reach the core
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_low_cnt <= 5'h00;
    end else if (i_external_reset_pin_n) begin
      pin_low_cnt <= 5'h00;
    end else if (pin_low_cnt != 5'h1F) begin
      pin_low_cnt <= pin_low_cnt + 5'h01;
    end
  end
  property p_reset_frozen; $fell(o_core_reset) && $past(o_core_freeze) |-> !o_core_freeze; endproperty
  a_reset_frozen: assert property (p_reset_frozen) else $error("core left reset before sequence end");
  property p_sleep_frozen; !o_osc_en |-> o_core_freeze; endproperty
  a_sleep_frozen: assert property (p_sleep_frozen) else $error("oscillator off while core runs");
  property p_fb_off; !o_osc_feedback_en |-> !o_osc_en; endproperty
  a_fb_off: assert property (p_fb_off) else $error("feedback off outside sleep");
  property p_src_legal; o_clk_src != 2'h3; endproperty
  a_src_legal: assert property (p_src_legal) else $error("illegal clock source");
  property p_src_frozen; !$stable(o_clk_src) |-> $past(o_core_freeze); endproperty
  a_src_frozen: assert property (p_src_frozen) else $error("source changed while core ran");
  property p_wdt_reset; i_watchdog_timer_evt && o_osc_en && !o_core_freeze |-> ##[1:6] o_core_reset; endproperty
  a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog gave no core reset");
  property p_instr_reset; i_reset_instr && !o_core_freeze |-> ##[1:6] o_core_reset; endproperty
  a_instr_reset: assert property (p_instr_reset) else $error("reset instruction ignored");
  property p_sleep_entry; i_sleep_req && i_first_quarter_phase && !o_core_freeze |-> ##[1:3] !o_osc_en; endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");
  property p_pin_hold; pin_low_cnt >= 5'h10 |-> o_core_reset; endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("long pin low without reset");
endmodule : csr_clock_reset_chk
bind csr_clock_reset csr_clock_reset_chk chk_u (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
  .i_external_reset_pin_n(i_external_reset_pin_n), .i_first_quarter_phase(i_first_quarter_phase),
  .i_sleep_req(i_sleep_req), .i_watchdog_timer_evt(i_watchdog_timer_evt), .i_reset_instr(i_reset_instr),
  .o_clk_src(o_clk_src), .o_core_freeze(o_core_freeze), .o_core_reset(o_core_reset), .o_osc_en(o_osc_en),
  .o_osc_feedback_en(o_osc_feedback_en));

// *** testbench/tb_clock_switch_and_reset_sequencer.sv ***
/*
  Self-checking bench for the clock switch and reset sequencer.
  Assumes csr_osc_model on the far side and a word-only AHB-Lite master here.
*/
`timescale 1ns/100ps
module tb_clock_switch_and_reset_sequencer;
  import csr_pkg::*;
  logic ref_clk = 1'b0, rstn = 1'b0, pin_low = 1'b0, cfg = 1'b0;
  logic sleep = 1'b0, irq = 1'b0, wdt = 1'b0, rinstr = 1'b0, hsel = 1'b0, hwrite = 1'b0, stk = 1'b0, prev;
  int rises;
  logic [2:0] mode = MODE_FAST_CRYSTAL;
  logic [1:0] q_cnt = 2'h0, htrans = 2'h0, clk_src;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
  logic main_osc, pll_clk, sec_osc, pin_n, hreadyout, hresp, sys_clk, freeze, core_rst, osc_en, fb_en;
  int err_total = 0, checks = 0, cyc;
  // Reference clock, 20 ns period
  initial forever #10 ref_clk = ~ref_clk;
  // Core phase marker, one cycle in four
  always @(posedge ref_clk) q_cnt <= q_cnt + 2'h1;
  csr_osc_model osc_u (.i_osc_en(osc_en), .i_pin_low(pin_low), .o_main_osc(main_osc), .o_pll_clk(pll_clk),
    .o_sec_osc(sec_osc), .o_reset_pin_n(pin_n));
  csr_clock_reset #(.POWERUP_CYCLES(40), .PLL_LOCK_CYCLES(20)) dut_u (.i_ref_clk(ref_clk), .i_rstn(rstn),
    .i_main_osc_in_pin(main_osc), .i_pll_clk(pll_clk), .i_sec_osc(sec_osc), .i_external_reset_pin_n(pin_n),
    .i_osc_mode(mode), .i_powerup_timer_cfg(cfg), .i_first_quarter_phase(q_cnt == 2'h0), .i_sleep_req(sleep),
    .i_wake_irq(irq), .i_watchdog_timer_evt(wdt), .i_reset_instr(rinstr), .i_stack_full(stk),
    .i_stack_underflow(1'b0), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout),
    .o_hresp(hresp), .o_sys_clk(sys_clk), .o_clk_src(clk_src), .o_core_freeze(freeze),
    .o_core_reset(core_rst), .o_osc_en(osc_en), .o_osc_feedback_en(fb_en));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Single word transfer; read data taken at the closing edge
  task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata, output logic [31:0] rdata);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= addr;
    hwrite <= wr;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wdata;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    rdata = hrdata;
  endtask : ahb
  // Lets the request land, then counts frozen cycles
  task automatic wait_run(output int n);
    n = 0;
    repeat (3) @(posedge ref_clk);
    while (freeze !== 1'b0 || core_rst !== 1'b0) begin
      @(posedge ref_clk);
      n++;
    end
  endtask : wait_run
  task automatic pulse_evt(input int which);
    if (which == 0) begin
      wdt <= 1'b1;
    end else if (which == 1) begin
      rinstr <= 1'b1;
    end else if (which == 2) begin
      irq <= 1'b1;
    end else begin
      stk <= 1'b1;
    end
    @(posedge ref_clk);
    stk <= 1'b0;
    wdt <= 1'b0;
    rinstr <= 1'b0;
    irq <= 1'b0;
  endtask : pulse_evt
  task automatic por(input logic [2:0] m, input logic c);
    rstn <= 1'b0;
    mode <= m;
    cfg <= c;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    wait_run(cyc);
  endtask : por
  task automatic s_boot;
    por(MODE_FAST_CRYSTAL, 1'b0);
    chk("boot_wait", 32'h1, {31'h0, cyc > 6100});
    ahb(1'b0, 32'h8, 32'h0, rd);
    chk("por_cause", 32'h1C, rd);
    chk("por_src", 32'h0, {30'h0, clk_src});
    chk("hresp_okay", 32'h0, {31'h0, hresp});
  endtask : s_boot
  task automatic s_switch;
    ahb(1'b1, 32'h0, 32'h1, rd);
    ahb(1'b0, 32'h0, 32'h0, rd);
    chk("pick_ignored", 32'h0, rd);
    ahb(1'b1, 32'h0, 32'h5, rd);
    wait_run(cyc);
    chk("sec_src", 32'h2, {30'h0, clk_src});
    chk("sec_sync", 32'h1, {31'h0, cyc >= 140});
    // Secondary source has a 20-cycle period, so 200 cycles hold ten rises
    rises = 0;
    prev = sys_clk;
    repeat (200) begin
      @(posedge ref_clk);
      if (sys_clk === 1'b1 && prev === 1'b0) rises++;
      prev = sys_clk;
    end
    chk("sec_sys_clk", 32'd10, rises);
    ahb(1'b1, 32'h0, 32'h4, rd);
    wait_run(cyc);
    chk("main_src", 32'h0, {30'h0, clk_src});
    chk("main_ost", 32'h1, {31'h0, cyc > 6100});
  endtask : s_switch
  task automatic s_sleep;
    sleep <= 1'b1;
    @(posedge ref_clk);
    while (osc_en !== 1'b0) @(posedge ref_clk);
    sleep <= 1'b0;
    chk("sleep_fb", 32'h0, {31'h0, fb_en});
    chk("sleep_freeze", 32'h1, {31'h0, freeze});
    pulse_evt(2);
    repeat (20) @(posedge ref_clk);
    chk("wake_no_reset", 32'h0, {31'h0, core_rst});
    wait_run(cyc);
    chk("wake_osc", 32'h1, {31'h0, osc_en});
    ahb(1'b0, 32'h8, 32'h0, rd);
    chk("wake_cause", 32'h10, rd);
  endtask : s_sleep
  task automatic s_resets;
    pulse_evt(0);
    wait_run(cyc);
    ahb(1'b0, 32'h0, 32'h0, rd);
    chk("wdt_ctrl", 32'h0, rd);
    ahb(1'b0, 32'h8, 32'h0, rd);
    chk("wdt_cause", 32'h14, rd);
    pulse_evt(1);
    wait_run(cyc);
    ahb(1'b0, 32'h8, 32'h0, rd);
    chk("instr_cause", 32'h04, rd);
    pulse_evt(3);
    wait_run(cyc);
    ahb(1'b0, 32'h8, 32'h0, rd);
    chk("stack_cause", 32'h24, rd);
  endtask : s_resets
  task automatic s_pin;
    pin_low <= 1'b1;
    repeat (4) @(posedge ref_clk);
    pin_low <= 1'b0;
    cyc = 0;
    repeat (20) begin
      @(posedge ref_clk);
      if (core_rst !== 1'b0) cyc++;
    end
    chk("pin_glitch", 32'h0, cyc);
    pin_low <= 1'b1;
    repeat (30) @(posedge ref_clk);
    chk("pin_reset", 32'h1, {31'h0, core_rst});
    pin_low <= 1'b0;
    wait_run(cyc);
    ahb(1'b0, 32'h8, 32'h0, rd);
    chk("pin_cause", 32'h24, rd);
  endtask : s_pin
  task automatic s_fast_boot;
    por(MODE_EXTERNAL_RNET, 1'b1);
    chk("rnet_nowait", 32'h1, {31'h0, cyc < 30});
    por(MODE_EXTERNAL_RNET, 1'b0);
    chk("rnet_powerup_timer", 32'h1, {31'h0, cyc >= 35 && cyc < 80});
  endtask : s_fast_boot
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict
  // Main sequence
  initial begin
    s_boot;
    s_switch;
    s_sleep;
    s_resets;
    s_pin;
    s_fast_boot;
    print_verdict;
  end
  // Hang guard, well beyond the roughly 19k cycles the run needs
  initial begin
    repeat (90000) @(posedge ref_clk);
    err_total++;
    print_verdict;
  end
endmodule : tb_clock_switch_and_reset_sequencer
